// *** shared/lterr_pkg.sv ***
// ************************************************************
// Register map and field layout
// ************************************************************
package lterr_pkg;
	// Byte offsets inside the block window
	localparam logic [15:0] LTERR_OFS_DET = 16'hC008;
	localparam logic [15:0] LTERR_OFS_EN = 16'hC00C;
	localparam logic [15:0] LTERR_OFS_HADDR = 16'hC010;
	localparam logic [15:0] LTERR_OFS_ADDR = 16'hC014;
	localparam logic [15:0] LTERR_OFS_ID = 16'hC018;
	localparam logic [15:0] LTERR_OFS_CTRL = 16'hC01C;
	localparam logic [15:0] LTERR_OFS_RSP_TO = 16'hC020;
	localparam logic [15:0] LTERR_OFS_MSG_TO = 16'hC024;
	// Detect bit positions
	localparam int LTERR_BIT_IO_RSP = 31;
	localparam int LTERR_BIT_MSG_RSP = 30;
	localparam int LTERR_BIT_SHM_RSP = 29;
	localparam int LTERR_BIT_FMT = 28;
	localparam int LTERR_BIT_DECODE = 27;
	localparam int LTERR_BIT_TGT = 26;
	localparam int LTERR_BIT_MSG_TO = 25;
	localparam int LTERR_BIT_RSP_TO = 24;
	localparam int LTERR_BIT_UNSOL = 23;
	localparam int LTERR_BIT_UNSUP = 22;
	localparam int LTERR_BIT_PDU_LEN = 14;
	localparam int LTERR_BIT_SHORT = 13;
	localparam int LTERR_BIT_LONG = 12;
	localparam int LTERR_BIT_OPEN = 11;
	localparam int LTERR_BIT_MISS = 10;
	localparam int LTERR_BIT_NO_CTX = 9;
	localparam int LTERR_BIT_QSEC = 7;
	localparam int LTERR_BIT_DMA = 6;
	// Implemented bits and capture classes
	localparam logic [31:0] LTERR_DET_IMPL = 32'hDBC07EC0;
	localparam logic [31:0] LTERR_EN_IMPL = 32'hFFC07EC0;
	localparam logic [31:0] LTERR_CAP_ADDR = 32'hC1000000;
	localparam logic [31:0] LTERR_CAP_ID = 32'hDBC07CC0;
	localparam logic [31:0] LTERR_CAP_CTRL = 32'hDAC07CC0;
	// Reset values
	localparam logic [31:0] LTERR_DET_RST = 32'h00000000;
	localparam logic [31:0] LTERR_EN_RST = 32'h00000000;
	localparam logic [31:0] LTERR_CAP_RST = 32'h00000000;
	// Time-out counters, in clock cycles
	localparam int LTERR_TO_W = 24;
	localparam logic [23:0] LTERR_TO_RST = 24'h00FFFF;
endpackage

// *** shared/lterr_tmr_if.sv ***
`timescale 1ns/10ps
// ************************************************************
// Time-out timer link
// ************************************************************
interface lterr_tmr_if #(
	parameter int W = 24
);
	logic arm;
	logic [W-1:0] limit;
	logic expire;
	modport ctl (output arm, output limit, input expire);
	modport tmr (input arm, input limit, output expire);
endinterface

// *** tb/lterr_far_model.sv ***
`timescale 1ns/10ps
// ************************************************************
// Remote endpoint: raises error events and offers details
// ************************************************************
module lterr_far_model (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Bench commands
	input wire logic i_fire,
	input wire logic [31:0] i_bits,
	input wire logic [31:0] i_info,
	input wire logic i_rsp_req,
	input wire logic i_msg_req,
	// Toward the block
	output logic [31:0] o_evt,
	output logic o_rsp_wait,
	output logic o_msg_wait,
	output logic [31:0] o_cap_addr_hi,
	output logic [31:0] o_cap_addr_lo,
	output logic [31:0] o_cap_id,
	output logic [31:0] o_cap_ctrl
);
	logic [31:0] junk_q;
	logic live;
	// Details churn when nothing is live, so a stray capture shows up
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			junk_q <= 32'h5A5A5A5A;
		end else begin
			junk_q <= ~junk_q + 32'h00000001;
		end
	end
	// Events last exactly the cycle the bench fires them
	assign live = i_fire | i_rsp_req | i_msg_req;
	assign o_evt = i_fire ? i_bits : 32'h00000000;
	assign o_rsp_wait = i_rsp_req;
	assign o_msg_wait = i_msg_req;
	assign o_cap_addr_hi = live ? i_info : junk_q;
	assign o_cap_addr_lo = live ? {i_info[15:0], i_info[31:16]} : ~junk_q;
	assign o_cap_id = live ? ~i_info : junk_q ^ 32'h0F0F0F0F;
	assign o_cap_ctrl = live ? i_info + 32'h00000001 : junk_q + 32'h00000003;
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
// ************************************************************
// Error report block bench
// ************************************************************
module tb_top
	import lterr_pkg::*;
;
	localparam logic [31:0] DET_MASK = 32'hDBC07EC0;
	localparam logic [31:0] EN_MASK = 32'hFFC07EC0;
	logic clk, rst, ce, hsel, hwrite, hrdy, hresp, report, locked;
	logic fire_r, rsp_req, msg_req, rsp_wait, msg_wait;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, bits, info, evt, c_hi, c_lo, c_id, c_ct;
	int n_fail, n_tests, cyc;
	lterr_top i_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_evt(evt), .i_rsp_wait(rsp_wait),
		.i_msg_wait(msg_wait), .i_cap_addr_hi(c_hi), .i_cap_addr_lo(c_lo), .i_cap_id(c_id),
		.i_cap_ctrl(c_ct), .o_report(report), .o_locked(locked));
	lterr_far_model i_far (.i_clk_sys(clk), .i_rst(rst), .i_fire(fire_r), .i_bits(bits), .i_info(info),
		.i_rsp_req(rsp_req), .i_msg_req(msg_req), .o_evt(evt), .o_rsp_wait(rsp_wait),
		.o_msg_wait(msg_wait), .o_cap_addr_hi(c_hi), .o_cap_addr_lo(c_lo), .o_cap_id(c_id),
		.o_cap_ctrl(c_ct));
	task automatic end_sim();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// One single AHB transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [15:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {16'h0000, ofs};
		hwrite <= wr;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [15:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, ofs, d, x);
	endtask
	task automatic rdchk(input logic [15:0] ofs, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, ofs, 32'h00000000, x);
		chk(x, e);
	endtask
	// One-cycle event pulse from the far end
	task automatic fire(input logic [31:0] b, input logic [31:0] v);
		@(posedge clk);
		fire_r <= 1'b1;
		bits <= b;
		info <= v;
		@(posedge clk);
		fire_r <= 1'b0;
		bits <= 32'h00000000;
	endtask
	task automatic t_reset();
		rdchk(LTERR_OFS_DET, 32'h00000000);
		rdchk(LTERR_OFS_EN, 32'h00000000);
		chk({31'h0, hresp}, 32'h00000000);
	endtask
	// Every position: only implemented bits stick, zero write clears
	task automatic t_bits();
		for (int b = 0; b < 32; b++) begin
			fire(32'h00000001 << b, 32'h00000000);
			rdchk(LTERR_OFS_DET, (32'h00000001 << b) & DET_MASK);
			chk({31'h0, report}, 32'h00000000);
			wr(LTERR_OFS_DET, 32'h00000000);
			rdchk(LTERR_OFS_DET, 32'h00000000);
		end
	endtask
	task automatic t_regs();
		wr(LTERR_OFS_DET, 32'hFFFFFFFF);
		rdchk(LTERR_OFS_DET, DET_MASK);
		wr(LTERR_OFS_DET, 32'h7FFFFFFF);
		rdchk(LTERR_OFS_DET, DET_MASK & 32'h7FFFFFFF);
		wr(LTERR_OFS_DET, 32'h00000000);
		wr(LTERR_OFS_EN, 32'hFFFFFFFF);
		rdchk(LTERR_OFS_EN, EN_MASK);
		wr(LTERR_OFS_EN, 32'h00000000);
		rdchk(LTERR_OFS_EN, 32'h00000000);
	endtask
	// Error responses capture all, lock out later errors until cleared
	task automatic t_capture();
		logic [31:0] v, w;
		for (int k = 30; k < 32; k++) begin
			v = 32'h12345600 + k;
			w = 32'hA5C3960F - k;
			wr(LTERR_OFS_EN, (32'h00000001 << k) | 32'h10000000);
			fire(32'h00000001 << k, v);
			@(negedge clk);
			chk({31'h0, locked}, 32'h00000001);
			@(negedge clk);
			chk({31'h0, report}, 32'h00000001);
			rdchk(LTERR_OFS_HADDR, v);
			rdchk(LTERR_OFS_ADDR, {v[15:0], v[31:16]});
			rdchk(LTERR_OFS_ID, ~v);
			rdchk(LTERR_OFS_CTRL, v + 32'h00000001);
			fire(32'h10000000, w);
			rdchk(LTERR_OFS_ID, ~v);
			wr(LTERR_OFS_DET, 32'h00000000);
			fire(32'h10000000, w);
			rdchk(LTERR_OFS_ID, ~w);
			rdchk(LTERR_OFS_CTRL, w + 32'h00000001);
			rdchk(LTERR_OFS_ADDR, {v[15:0], v[31:16]});
			wr(LTERR_OFS_DET, 32'h00000000);
			repeat (2) @(negedge clk);
			chk({30'h0, locked, report}, 32'h00000000);
		end
	endtask
	// Short time-outs: response then message wait expires
	task automatic t_timeout();
		wr(LTERR_OFS_RSP_TO, 32'h00000003);
		wr(LTERR_OFS_MSG_TO, 32'h00000003);
		wr(LTERR_OFS_EN, 32'h03000000);
		@(posedge clk);
		rsp_req <= 1'b1;
		info <= 32'h0BADF00D;
		repeat (6) @(posedge clk);
		rsp_req <= 1'b0;
		rdchk(LTERR_OFS_DET, 32'h01000000);
		rdchk(LTERR_OFS_HADDR, 32'h0BADF00D);
		rdchk(LTERR_OFS_ADDR, 32'hF00D0BAD);
		rdchk(LTERR_OFS_ID, 32'hF4520FF2);
		wr(LTERR_OFS_DET, 32'h00000000);
		repeat (2) @(posedge clk);
		msg_req <= 1'b1;
		info <= 32'h00C0FFEE;
		repeat (6) @(posedge clk);
		msg_req <= 1'b0;
		rdchk(LTERR_OFS_DET, 32'h02000000);
		rdchk(LTERR_OFS_ID, 32'hFF3F0011);
		rdchk(LTERR_OFS_CTRL, 32'h00C0FFEF);
	endtask
	// A clear and a decode error in one cycle: the error must survive
	task automatic t_race();
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {16'h0000, LTERR_OFS_DET};
		hwrite <= 1'b1;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= 32'h00000000;
		fire_r <= 1'b1;
		bits <= 32'h08000000;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		fire_r <= 1'b0;
		bits <= 32'h00000000;
		rdchk(LTERR_OFS_DET, 32'h08000000);
		wr(LTERR_OFS_DET, 32'h00000000);
	endtask
	// Clock enable low: an event pulse must leave no trace
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		fire(32'h00800000, 32'h00000000);
		@(posedge clk);
		ce <= 1'b1;
		rdchk(LTERR_OFS_DET, 32'h00000000);
	endtask
	// Streaming error after the lock is freed captures id and control
	task automatic t_stream();
		wr(LTERR_OFS_DET, 32'h00000000);
		wr(LTERR_OFS_EN, 32'h00004000);
		fire(32'h00004000, 32'h13572468);
		rdchk(LTERR_OFS_ID, 32'hECA8DB97);
		rdchk(LTERR_OFS_CTRL, 32'h13572469);
		chk({31'h0, locked}, 32'h00000001);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		fire_r = 1'b0;
		bits = 32'h00000000;
		info = 32'h00000000;
		rsp_req = 1'b0;
		msg_req = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_bits();
		t_regs();
		t_race();
		t_freeze();
		t_capture();
		t_timeout();
		t_stream();
		end_sim();
	end
endmodule

// *** verilog/lterr_timer.sv ***
`timescale 1ns/10ps
// ************************************************************
// One-shot wait timer
// ************************************************************
module lterr_timer #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	// Control side
	lterr_tmr_if.tmr tmr
);
	logic [W-1:0] cnt_q;
	logic done_q;
	logic exp_q;
	logic hit;

	// Limit of zero disables the timer
	assign hit = tmr.arm && !done_q && (tmr.limit != '0) && (cnt_q == tmr.limit - 1'b1);
	assign tmr.expire = exp_q;

	// Count while the wait is armed until it fires, restart when it drops
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			if (!tmr.arm) begin
				cnt_q <= '0;
			end else if (!done_q) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Fire once per armed wait
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			done_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (i_ce) begin
			exp_q <= hit;
			if (!tmr.arm) begin
				done_q <= 1'b0;
			end else if (hit) begin
				done_q <= 1'b1;
			end
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_tmr_one_shot: assert property (exp_q && i_ce |=> !exp_q) // RULE7
		else $error("timer expiry lasted more than one cycle");
endmodule

// *** verilog/lterr_top.sv ***
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// RULE1 - IO and message error responses set 31, 30
// RULE2 - Sticky bits; write zero clears, one sets
// RULE3 - Bits 29 and 26 always read zero
// RULE4 - Bad message payload size or segment sets 28
// RULE5 - Illegal fields in supported transaction set 27
// RULE6 - Missing message request time-out sets 25
// RULE7 - Missing response time-out sets 24
// RULE8 - Unmatched response packet sets 23
// RULE9 - Unsupported received transaction sets 22
// RULE10 - Reassembled length mismatch sets 14
// RULE11 - Short segment sets 13, long sets 12
// RULE12 - Open context 11, missing context 10
// RULE13 - No free context drops packet, sets 9
// RULE14 - Blocked receive queue access sets 7
// RULE15 - Blocked inbound DMA access sets 6
// RULE16 - Enable register mirrors detect bit positions
// RULE17 - IO error response captures all fields
// RULE18 - Message error response captures all fields
// RULE19 - Response time-out captures address and identifier
// RULE20 - Bits 28,27,23,22 capture identifier and control
// RULE21 - Message time-out captures last segment fields
// RULE22 - Streaming errors capture relevant fields
// RULE23 - Captures stay locked until cause cleared
module lterr_top
	import lterr_pkg::*;
(
	// Clock, reset, clock enable
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Error events from the packet logic, one pulse per bit position
	input wire logic [31:0] i_evt,
	// Outstanding waits watched by the time-out timers
	input wire logic i_rsp_wait,
	input wire logic i_msg_wait,
	// Transaction details offered for capture
	input wire logic [31:0] i_cap_addr_hi,
	input wire logic [31:0] i_cap_addr_lo,
	input wire logic [31:0] i_cap_id,
	input wire logic [31:0] i_cap_ctrl,
	// Status
	output logic o_report,
	output logic o_locked
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic aphase;
	logic wr_q;
	logic [15:0] wadr_q;
	logic [31:0] hrdata_q;
	logic hready_q;
	logic hresp_q;
	logic [31:0] rd_val;
	logic wr_det;
	logic wr_en;
	logic wr_rsp_to;
	logic wr_msg_to;
	logic [31:0] det_q;
	logic [31:0] en_q;
	logic [31:0] evt_all;
	logic [31:0] hit;
	logic lock_free;
	logic take;
	logic lock_q;
	logic [31:0] src_q;
	logic [31:0] haddr_cap_q;
	logic [31:0] addr_cap_q;
	logic [31:0] id_cap_q;
	logic [31:0] ctrl_cap_q;
	logic [LTERR_TO_W-1:0] rsp_to_q;
	logic [LTERR_TO_W-1:0] msg_to_q;
	logic report_q;

	lterr_tmr_if #(.W(LTERR_TO_W)) rsp_tmr ();
	lterr_tmr_if #(.W(LTERR_TO_W)) msg_tmr ();

	// ************************************************************
	// Time-out timers
	// ************************************************************

	// Response wait covers outstanding IO and message requests
	assign rsp_tmr.arm = i_rsp_wait;
	assign rsp_tmr.limit = rsp_to_q;
	assign msg_tmr.arm = i_msg_wait;
	assign msg_tmr.limit = msg_to_q;

	lterr_timer #(.W(LTERR_TO_W)) u_rsp_tmr (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.tmr(rsp_tmr.tmr)
	);

	lterr_timer #(.W(LTERR_TO_W)) u_msg_tmr (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.tmr(msg_tmr.tmr)
	);

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************

	// Only a selected NONSEQ or SEQ with the bus ready opens a transfer
	assign aphase = i_hsel && i_htrans[1] && i_hready;

	// Address phase latch for the write data phase
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wr_q <= 1'b0;
			wadr_q <= 16'h0000;
		end else if (i_ce) begin
			if (i_hready) begin
				wr_q <= aphase && i_hwrite;
				wadr_q <= i_haddr[15:0];
			end
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end else if (i_ce) begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// Read data is sampled at the address phase so it can leave a flop
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			hrdata_q <= 32'h00000000;
		end else if (i_ce) begin
			if (aphase && !i_hwrite) begin
				hrdata_q <= rd_val;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		unique case (i_haddr[15:0])
			LTERR_OFS_DET: rd_val = det_q;
			LTERR_OFS_EN: rd_val = en_q;
			LTERR_OFS_HADDR: rd_val = haddr_cap_q;
			LTERR_OFS_ADDR: rd_val = addr_cap_q;
			LTERR_OFS_ID: rd_val = id_cap_q;
			LTERR_OFS_CTRL: rd_val = ctrl_cap_q;
			LTERR_OFS_RSP_TO: rd_val = {8'h00, rsp_to_q};
			LTERR_OFS_MSG_TO: rd_val = {8'h00, msg_to_q};
			default: rd_val = 32'h00000000;
		endcase
	end

	// Write strobes in the data phase
	assign wr_det = wr_q && (wadr_q == LTERR_OFS_DET);
	assign wr_en = wr_q && (wadr_q == LTERR_OFS_EN);
	assign wr_rsp_to = wr_q && (wadr_q == LTERR_OFS_RSP_TO);
	assign wr_msg_to = wr_q && (wadr_q == LTERR_OFS_MSG_TO);

	assign o_hrdata = hrdata_q;
	assign o_hreadyout = hready_q;
	assign o_hresp = hresp_q;

	// ************************************************************
	// Detect register
	// ************************************************************

	// Unsupported classes are masked off here, so 29 and 26 never rise
	always_comb begin
		evt_all = i_evt; // RULE1 RULE4 RULE5 RULE8 RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15
		evt_all[LTERR_BIT_MSG_TO] = i_evt[LTERR_BIT_MSG_TO] | msg_tmr.expire; // RULE6
		evt_all[LTERR_BIT_RSP_TO] = i_evt[LTERR_BIT_RSP_TO] | rsp_tmr.expire; // RULE7
		evt_all = evt_all & LTERR_DET_IMPL; // RULE3
	end

	// A hardware event wins over a software clear in the same cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			det_q <= LTERR_DET_RST;
		end else if (i_ce) begin
			if (wr_det) begin
				det_q <= (i_hwdata | evt_all) & LTERR_DET_IMPL; // RULE2
			end else begin
				det_q <= det_q | evt_all; // RULE2
			end
		end
	end

	// ************************************************************
	// Enable and time-out registers
	// ************************************************************

	// Enable bits sit at the detect positions
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			en_q <= LTERR_EN_RST;
		end else if (i_ce) begin
			if (wr_en) begin
				en_q <= i_hwdata & LTERR_EN_IMPL; // RULE16
			end
		end
	end

	// Time-out intervals in clock cycles
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rsp_to_q <= LTERR_TO_RST;
			msg_to_q <= LTERR_TO_RST;
		end else if (i_ce) begin
			if (wr_rsp_to) begin
				rsp_to_q <= i_hwdata[LTERR_TO_W-1:0];
			end
			if (wr_msg_to) begin
				msg_to_q <= i_hwdata[LTERR_TO_W-1:0];
			end
		end
	end

	// ************************************************************
	// Capture and lock
	// ************************************************************

	// Enabled events that save details; no-context drops save nothing
	assign hit = evt_all & en_q & LTERR_CAP_ID;
	// Lock frees once software has cleared every bit that caused it
	assign lock_free = !lock_q || ((det_q & src_q) == 32'h00000000); // RULE23
	assign take = lock_free && (hit != 32'h00000000);

	// Lock state remembers which detect bits froze the captures
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			lock_q <= 1'b0;
			src_q <= 32'h00000000;
		end else if (i_ce) begin
			if (take) begin
				lock_q <= 1'b1;
				src_q <= hit;
			end else if (lock_free) begin
				lock_q <= 1'b0; // RULE23
				src_q <= 32'h00000000;
			end
		end
	end

	// Address captures only for error responses and response time-out
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			haddr_cap_q <= LTERR_CAP_RST;
			addr_cap_q <= LTERR_CAP_RST;
		end else if (i_ce) begin
			if (take && ((hit & LTERR_CAP_ADDR) != 32'h00000000)) begin
				haddr_cap_q <= i_cap_addr_hi; // RULE17 RULE18 RULE19
				addr_cap_q <= i_cap_addr_lo; // RULE17 RULE18 RULE19
			end
		end
	end

	// Identifier capture for every capturing class
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			id_cap_q <= LTERR_CAP_RST;
		end else if (i_ce) begin
			if (take) begin
				id_cap_q <= i_cap_id; // RULE19 RULE20 RULE21 RULE22
			end
		end
	end

	// Control capture for all but the response time-out
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctrl_cap_q <= LTERR_CAP_RST;
		end else if (i_ce) begin
			if (take && ((hit & LTERR_CAP_CTRL) != 32'h00000000)) begin
				ctrl_cap_q <= i_cap_ctrl; // RULE17 RULE18 RULE20 RULE21 RULE22
			end
		end
	end

	// ************************************************************
	// Reporting
	// ************************************************************

	// Reported means a detect bit stands with its enable set
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			report_q <= 1'b0;
		end else if (i_ce) begin
			report_q <= (det_q & en_q) != 32'h00000000; // RULE17 RULE18 RULE19 RULE20 RULE21 RULE22
		end
	end

	assign o_report = report_q;
	assign o_locked = lock_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sequence s_io_rsp;
		i_ce && i_evt[LTERR_BIT_IO_RSP];
	endsequence

	sequence s_free_take(int b);
		i_ce && lock_free && i_evt[b] && en_q[b];
	endsequence

	chk_io_rsp_set: assert property (s_io_rsp |=> det_q[LTERR_BIT_IO_RSP]) // RULE1
		else $error("IO error response did not set its detect bit");

	chk_det_sticky: assert property (i_ce && !wr_det |=> (det_q & $past(det_q)) == $past(det_q)) // RULE2
		else $error("detect bit dropped without a write");

	chk_unsup_zero: assert property ((det_q & ~LTERR_DET_IMPL) == 32'h00000000) // RULE3
		else $error("unsupported detect bit read as one");

	chk_set_wins: assert property (i_ce && wr_det && i_evt[LTERR_BIT_DECODE] |=> det_q[LTERR_BIT_DECODE]) // RULE5
		else $error("clear won over a decode error event");

	chk_msg_to_set: assert property (i_ce && msg_tmr.expire |=> det_q[LTERR_BIT_MSG_TO]) // RULE6
		else $error("message time-out did not set its detect bit");

	chk_rsp_to_delay: assert property ($rose(i_rsp_wait) && i_ce && rsp_to_q == 24'h000003 ##1 (i_ce && i_rsp_wait && !wr_rsp_to) [*3] |-> rsp_tmr.expire) // RULE7
		else $error("response time-out missed its count");

	chk_en_reserved: assert property ((en_q & ~LTERR_EN_IMPL) == 32'h00000000) // RULE16
		else $error("reserved enable bit read as one");

	chk_io_capture: assert property (s_free_take(LTERR_BIT_IO_RSP) |=> lock_q && addr_cap_q == $past(i_cap_addr_lo) && ctrl_cap_q == $past(i_cap_ctrl)) // RULE17
		else $error("IO error response not captured");

	chk_rsp_to_ctrl: assert property (i_ce && lock_free && hit == 32'h01000000 |=> $stable(ctrl_cap_q) && id_cap_q == $past(i_cap_id)) // RULE19
		else $error("response time-out capture wrong");

	chk_lock_hold: assert property (i_ce && !lock_free |=> $stable(id_cap_q) && $stable(addr_cap_q)) // RULE23
		else $error("locked capture was overwritten");

	chk_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("slave answered other than OKAY");
endmodule
